/* File: verilog/wdog_pkg.sv */
package wdog_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [11:0] watchdog_control_status_addr     = 12'hff0;
  localparam logic [11:0] watchdog_reload_upper_byte_addr  = 12'hff1;
  localparam logic [11:0] watchdog_reload_high_byte_addr   = 12'hff2;
  localparam logic [11:0] watchdog_reload_low_byte_addr    = 12'hff3;

  // ****************************************
  // Field positions and values
  // ****************************************
  localparam int          por_flag_pos            = 7;
  localparam int          stop_flag_pos           = 6;
  localparam int          timeout_flag_pos        = 5;
  localparam int          pin_reset_flag_pos      = 4;
  localparam int          stop_mode_shutoff_pos   = 0;
  localparam logic [7:0]  unlock_first            = 8'h55;
  localparam logic [7:0]  unlock_second           = 8'haa;
  localparam logic [7:0]  shutoff_set_value       = 8'h81;
  localparam logic [7:0]  shutoff_clear_value     = 8'h00;
  localparam logic [23:0] reload_reset_value      = 24'hffffff;
  localparam logic [23:0] count_max               = 24'hffffff;
  localparam logic [23:0] refresh_block_count     = 24'h000002;
  localparam logic [23:0] count_zero              = 24'h000000;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0] {
    lock_idle,
    lock_got_first,
    lock_got_second,
    lock_upper_done,
    lock_high_done
  } lock_state_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [11:0] addr;
    logic [7:0]  wdata;
  } reg_req_t;

  typedef struct packed {
    logic por_reset;
    logic dbg_reset;
    logic debug_pin_stop_reset;
    logic ext_pin_reset;
    logic gpio_stop_recovery;
  } reset_cause_t;

endpackage

/* File: verilog/wdog_counter.sv */
`timescale 1ns/1ps
module wdog_counter
#(
  parameter int width = 24
)
(
  input  wire logic             mclk,
  input  wire logic             rst_b,
  input  wire logic             tick,
  input  wire logic             load,
  input  wire logic [width-1:0] load_value,
  output logic      [width-1:0] count,
  output logic                  at_zero
);

  initial
  begin
    if (width != 24)
      $error("wdog_counter width must be 24");
  end

  // ****************************************
  // Down counter with roll-over at zero
  // ****************************************
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
      count <= wdog_pkg::count_max;
    else if (load)
      count <= load_value;
    else if (tick)
      count <= count - 24'h000001;  // [R20] [R21]
  end

  assign at_zero = tick && !load && (count == wdog_pkg::count_zero);  // [R20]

endmodule

/* File: verilog/wdog_regs.sv */
`timescale 1ns/1ps
// Contract
// (R1) Status read-only; read clears upper four flags
// (R2) Writing 55h then aah unlocks reload bytes
// (R3) Unlock writes leave status bits unchanged
// (R4) Power-on, debugger, debug pin: power-on flag only
// (R5) External pin reset sets pin-reset flag only
// (R6) Normal time-out reset sets time-out flag only
// (R7) GPIO stop recovery sets stop flag only
// (R8) Stop-mode time-out sets stop and time-out flags
// (R9) Time-out or stop recovery clears power-on flag
// (R10) Stop flag cleared by power-on, normal time-out
// (R11) Time-out flag cleared by power-on, GPIO recovery
// (R12) Pin-reset flag set by pin, cleared likewise
// (R13) Reserved status bits read zero
// (R14) Shutoff bit: 0 runs, 1 stops in stop
// (R15) Reload is upper, high, low concatenated
// (R16) Refresh instruction copies reload into counter
// (R17) Reload writes store; reads return live count
// (R18) Software never programs reload below 000004h
// (R19) Upper, high, low in order; else relock
// (R20) Count down, time out at zero
// (R21) Interrupt mode rolls over and keeps counting
// (R22) Refresh ignored once counter reaches 000002h
// (R23) Reload writes accepted only while unlocked
module wdog_regs
(
  input  wire logic                  mclk,
  input  wire logic                  rst_b,
  input  wire wdog_pkg::reg_req_t    req,
  output logic      [7:0]            rdata,
  input  wire wdog_pkg::reset_cause_t cause,
  input  wire logic                  rc_tick,
  input  wire logic                  refresh,
  input  wire logic                  enable,
  input  wire logic                  debug_mode,
  input  wire logic                  stop_mode,
  input  wire logic                  timeout_response_option,
  output logic                       timeout_irq,
  output logic                       timeout_reset,
  output logic                       stop_recovery,
  output logic                       wdog_clock_run
);

  // ****************************************
  // State
  // ****************************************
  logic                  por_flag;
  logic                  stop_flag;
  logic                  timeout_flag;
  logic                  pin_reset_flag;
  logic                  stop_mode_shutoff_bit;
  logic [23:0]           reload;
  logic [23:0]           count;
  logic                  at_zero;
  logic                  running;
  logic                  load;
  logic                  wr_ctl;
  logic                  wr_upper;
  logic                  wr_high;
  logic                  wr_low;
  logic                  rd_ctl;
  logic                  any_reset;
  logic                  tick;
  logic                  to_normal;
  logic                  to_stop;
  logic                  shutoff_armed;
  wdog_pkg::lock_state_t lock_state;
  wdog_pkg::lock_state_t next_lock_state;

  assign wr_ctl    = req.wr && req.addr == wdog_pkg::watchdog_control_status_addr;
  assign wr_upper  = req.wr && req.addr == wdog_pkg::watchdog_reload_upper_byte_addr;
  assign wr_high   = req.wr && req.addr == wdog_pkg::watchdog_reload_high_byte_addr;
  assign wr_low    = req.wr && req.addr == wdog_pkg::watchdog_reload_low_byte_addr;
  assign rd_ctl    = req.rd && req.addr == wdog_pkg::watchdog_control_status_addr;
  assign any_reset = cause.por_reset || cause.dbg_reset || cause.debug_pin_stop_reset;

  // ****************************************
  // Unlock state machine
  // ****************************************
  always_comb
  begin
    next_lock_state = lock_state;
    if (req.wr)
    begin
      next_lock_state = wdog_pkg::lock_idle;  // [R19]
      case (lock_state)
        wdog_pkg::lock_idle:
          if (wr_ctl && req.wdata == wdog_pkg::unlock_first)
            next_lock_state = wdog_pkg::lock_got_first;  // [R2]
        wdog_pkg::lock_got_first:
          if (wr_ctl && req.wdata == wdog_pkg::unlock_second)
            next_lock_state = wdog_pkg::lock_got_second;  // [R2]
        wdog_pkg::lock_got_second:
          if (wr_upper)
            next_lock_state = wdog_pkg::lock_upper_done;  // [R19]
          else if (wr_ctl && req.wdata == wdog_pkg::unlock_first)
            next_lock_state = wdog_pkg::lock_got_first;
        wdog_pkg::lock_upper_done:
          if (wr_high)
            next_lock_state = wdog_pkg::lock_high_done;  // [R19]
        default:
          if (wr_ctl && req.wdata == wdog_pkg::unlock_first)
            next_lock_state = wdog_pkg::lock_got_first;
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
      lock_state <= wdog_pkg::lock_idle;
    else
      lock_state <= next_lock_state;
  end

  // ****************************************
  // Reload bytes
  // ****************************************
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
      reload <= wdog_pkg::reload_reset_value;
    else if (wr_upper && lock_state == wdog_pkg::lock_got_second)
      reload[23:16] <= req.wdata;  // [R15] [R23]
    else if (wr_high && lock_state == wdog_pkg::lock_upper_done)
      reload[15:8] <= req.wdata;  // [R15] [R23]
    else if (wr_low && lock_state == wdog_pkg::lock_high_done)
      reload[7:0] <= req.wdata;  // [R15] [R17] [R23]
  end

  // ****************************************
  // Stop-mode shutoff bit via 55h, aah, value
  // ****************************************
  // Armed from the second unlock byte until the next write
  assign shutoff_armed = lock_state == wdog_pkg::lock_got_second;  // [R14]

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
      stop_mode_shutoff_bit <= 1'b0;
    else if (shutoff_armed && wr_ctl && req.wdata == wdog_pkg::shutoff_set_value)
      stop_mode_shutoff_bit <= 1'b1;  // [R14]
    else if (shutoff_armed && wr_ctl && req.wdata == wdog_pkg::shutoff_clear_value)
      stop_mode_shutoff_bit <= 1'b0;  // [R14]
  end

  assign wdog_clock_run = !(stop_mode && stop_mode_shutoff_bit);  // [R14]

  // ****************************************
  // Counter
  // ****************************************
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
      running <= 1'b0;
    else if (enable || refresh)
      running <= 1'b1;
  end

  assign tick = running && rc_tick && wdog_clock_run;
  assign load = (!running && (enable || refresh))
                || (running && (refresh || debug_mode)
                    && count > wdog_pkg::refresh_block_count);  // [R16] [R22]

  wdog_counter #(.width(24)) u_counter
  (
    .mclk       (mclk),
    .rst_b      (rst_b),
    .tick       (tick),
    .load       (load),
    .load_value (reload),  // [R16]
    .count      (count),
    .at_zero    (at_zero)
  );

  assign to_normal     = at_zero && !stop_mode;
  assign to_stop       = at_zero && stop_mode;
  assign timeout_irq   = at_zero && !timeout_response_option;  // [R20] [R21]
  assign timeout_reset = to_normal && timeout_response_option;  // [R20]
  assign stop_recovery = to_stop;

  // ****************************************
  // Status flags
  // ****************************************
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
      por_flag <= 1'b1;
    else if (any_reset)
      por_flag <= 1'b1;  // [R4]
    else if (at_zero || cause.gpio_stop_recovery || cause.ext_pin_reset)
      por_flag <= 1'b0;  // [R5] [R9]
    else if (rd_ctl)
      por_flag <= 1'b0;  // [R1]
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
      stop_flag <= 1'b0;
    else if (to_stop || cause.gpio_stop_recovery)
      stop_flag <= 1'b1;  // [R7] [R8]
    else if (any_reset || to_normal || cause.ext_pin_reset)
      stop_flag <= 1'b0;  // [R4] [R6] [R10]
    else if (rd_ctl)
      stop_flag <= 1'b0;  // [R1]
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
      timeout_flag <= 1'b0;
    else if (at_zero)
      timeout_flag <= 1'b1;  // [R6] [R8]
    else if (any_reset || cause.gpio_stop_recovery || cause.ext_pin_reset)
      timeout_flag <= 1'b0;  // [R4] [R11]
    else if (rd_ctl)
      timeout_flag <= 1'b0;  // [R1]
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
      pin_reset_flag <= 1'b0;
    else if (cause.ext_pin_reset)
      pin_reset_flag <= 1'b1;  // [R5] [R12]
    else if (any_reset || at_zero || cause.gpio_stop_recovery)
      pin_reset_flag <= 1'b0;  // [R4] [R6] [R12]
    else if (rd_ctl)
      pin_reset_flag <= 1'b0;  // [R1]
  end

  // ****************************************
  // Read data
  // ****************************************
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
      rdata <= 8'h00;
    else if (req.addr == wdog_pkg::watchdog_control_status_addr)
      rdata <= {por_flag, stop_flag, timeout_flag, pin_reset_flag,
                3'h0, stop_mode_shutoff_bit};  // [R13] [R14]
    else if (req.addr == wdog_pkg::watchdog_reload_upper_byte_addr)
      rdata <= count[23:16];  // [R17]
    else if (req.addr == wdog_pkg::watchdog_reload_high_byte_addr)
      rdata <= count[15:8];  // [R17]
    else if (req.addr == wdog_pkg::watchdog_reload_low_byte_addr)
      rdata <= count[7:0];  // [R17]
    else
      rdata <= 8'h00;
  end

  // ****************************************
  // Checks
  // ****************************************
  sequence first_unlock_byte;
    lock_state == wdog_pkg::lock_idle && wr_ctl && req.wdata == wdog_pkg::unlock_first;
  endsequence

  sequence second_unlock_byte;
    lock_state == wdog_pkg::lock_got_first && wr_ctl
    && req.wdata == wdog_pkg::unlock_second;
  endsequence

  AST_UNLOCK_FIRST: assert property (@(posedge mclk) disable iff (!rst_b)
    first_unlock_byte |=> lock_state == wdog_pkg::lock_got_first)  // [R2]
    else $error("first unlock byte not taken");

  AST_UNLOCK_OPENS: assert property (@(posedge mclk) disable iff (!rst_b)
    second_unlock_byte |=> lock_state == wdog_pkg::lock_got_second)  // [R2]
    else $error("unlock pair did not open reload bytes");

  AST_PIN_RESET: assert property (@(posedge mclk) disable iff (!rst_b)
    (cause.ext_pin_reset && !any_reset && !at_zero && !cause.gpio_stop_recovery) |=>
    {por_flag, stop_flag, timeout_flag, pin_reset_flag} == 4'h1)  // [R5]
    else $error("pin reset flag pattern wrong");

  AST_NORMAL_TIMEOUT: assert property (@(posedge mclk) disable iff (!rst_b)
    (to_normal && cause == '0) |=>
    {por_flag, stop_flag, timeout_flag, pin_reset_flag} == 4'h2)  // [R6]
    else $error("normal time-out flag pattern wrong");

  AST_RESERVED_ZERO: assert property (@(posedge mclk) disable iff (!rst_b)
    $past(req.addr) == wdog_pkg::watchdog_control_status_addr |-> rdata[3:1] == 3'h0)  // [R13]
    else $error("reserved status bits not zero");

  AST_READ_LIVE_LOW: assert property (@(posedge mclk) disable iff (!rst_b)
    $past(req.addr) == wdog_pkg::watchdog_reload_low_byte_addr |->
    rdata == $past(count[7:0]))  // [R17]
    else $error("low byte read not live count");

  AST_UNLOCK_KEEPS_FLAGS: assert property (@(posedge mclk) disable iff (!rst_b)
    (wr_ctl && !rd_ctl && !at_zero && cause == '0) |=>
    $stable({por_flag, stop_flag, timeout_flag, pin_reset_flag}))  // [R3]
    else $error("control write changed flags");

  AST_READ_CLEARS: assert property (@(posedge mclk) disable iff (!rst_b)
    (rd_ctl && !at_zero && cause == '0) |=>
    {por_flag, stop_flag, timeout_flag, pin_reset_flag} == 4'h0)  // [R1]
    else $error("status read did not clear flags");

  AST_POR_FLAGS: assert property (@(posedge mclk) disable iff (!rst_b)
    (any_reset && !at_zero && !cause.gpio_stop_recovery && !cause.ext_pin_reset) |=>
    {por_flag, stop_flag, timeout_flag, pin_reset_flag} == 4'h8)  // [R4]
    else $error("power-on flag pattern wrong");

  AST_STOP_TIMEOUT: assert property (@(posedge mclk) disable iff (!rst_b)
    (to_stop && !cause.ext_pin_reset && !any_reset) |=>
    {por_flag, stop_flag, timeout_flag, pin_reset_flag} == 4'h6)  // [R8]
    else $error("stop time-out flag pattern wrong");

  AST_GPIO_RECOVERY: assert property (@(posedge mclk) disable iff (!rst_b)
    (cause.gpio_stop_recovery && !at_zero && !cause.ext_pin_reset && !any_reset) |=>
    {por_flag, stop_flag, timeout_flag, pin_reset_flag} == 4'h4)  // [R7]
    else $error("gpio recovery flag pattern wrong");

  AST_REFRESH_BLOCKED: assert property (@(posedge mclk) disable iff (!rst_b)
    (running && count <= wdog_pkg::refresh_block_count) |-> !load)  // [R22]
    else $error("refresh taken below block count");

  AST_REFRESH_LOADS: assert property (@(posedge mclk) disable iff (!rst_b)
    (running && refresh && count > wdog_pkg::refresh_block_count) |=>
    count == $past(reload))  // [R16]
    else $error("refresh did not load reload");

  AST_ROLLOVER: assert property (@(posedge mclk) disable iff (!rst_b)
    at_zero |=> count == wdog_pkg::count_max)  // [R21]
    else $error("counter did not roll over");

  AST_LOCKED_WRITE: assert property (@(posedge mclk) disable iff (!rst_b)
    ((wr_upper && lock_state != wdog_pkg::lock_got_second)
     || (wr_high && lock_state != wdog_pkg::lock_upper_done)
     || (wr_low && lock_state != wdog_pkg::lock_high_done)) |=> $stable(reload))  // [R23]
    else $error("locked reload write took effect");

endmodule

/* File: tb/wdog_cpu_model.sv */
`timescale 1ns/1ps
// ****************************************
// CPU register bus model
// ****************************************
module wdog_cpu_model
(
  input  wire logic          mclk,
  input  wire logic [7:0]    rdata,
  output wdog_pkg::reg_req_t req
);
  initial
  begin
    req = '0;
  end

  // One write cycle, then a gap; released data is inverted
  task automatic bus_write(input logic [11:0] addr, input logic [7:0] data);
    @(posedge mclk);
    #1;
    req.wr    = 1'b1;
    req.addr  = addr;
    req.wdata = data;
    @(posedge mclk);
    #1;
    req.wr    = 1'b0;
    req.wdata = ~data;
  endtask

  // One read cycle; data taken one cycle after the strobe
  task automatic bus_read(input logic [11:0] addr, output logic [7:0] data);
    @(posedge mclk);
    #1;
    req.rd   = 1'b1;
    req.addr = addr;
    @(posedge mclk);
    #1;
    req.rd = 1'b0;
    data   = rdata;
  endtask

  // Two-byte unlock at the status address
  task automatic unlock;
    bus_write(wdog_pkg::watchdog_control_status_addr, wdog_pkg::unlock_first);
    bus_write(wdog_pkg::watchdog_control_status_addr, wdog_pkg::unlock_second);
  endtask

  // Reload bytes upper, high, low; callers keep the value at four or more
  task automatic set_reload(input logic [23:0] value);
    unlock();
    bus_write(wdog_pkg::watchdog_reload_upper_byte_addr, value[23:16]);
    bus_write(wdog_pkg::watchdog_reload_high_byte_addr, value[15:8]);
    bus_write(wdog_pkg::watchdog_reload_low_byte_addr, value[7:0]);
  endtask
endmodule

/* File: tb/watchdog_status_and_reload_regs_test.sv */
`timescale 1ns/1ps
module watchdog_status_and_reload_regs_test;
  logic                    mclk;
  logic                    rst_b;
  wdog_pkg::reg_req_t      req;
  logic [7:0]              rdata;
  wdog_pkg::reset_cause_t  cause;
  logic                    rc_tick;
  logic                    refresh;
  logic                    enable;
  logic                    stop_mode;
  logic                    tro;
  logic                    irq;
  logic                    trst;
  logic                    srec;
  logic                    run;
  int                      n_errors;
  int                      checked;
  logic [4:0]              row_cause [5] = '{5'h10, 5'h08, 5'h04, 5'h02, 5'h01};
  logic [7:0]              row_stat  [5] = '{8'h80, 8'h80, 8'h80, 8'h10, 8'h40};

  wdog_regs i_wdog_regs (.mclk(mclk), .rst_b(rst_b), .req(req), .rdata(rdata), .cause(cause),
    .rc_tick(rc_tick), .refresh(refresh), .enable(enable), .debug_mode(1'b0),
    .stop_mode(stop_mode), .timeout_response_option(tro), .timeout_irq(irq),
    .timeout_reset(trst), .stop_recovery(srec), .wdog_clock_run(run));
  wdog_cpu_model i_wdog_cpu_model (.mclk(mclk), .rdata(rdata), .req(req));

  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test;
    $display("Checks %0d, errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic rd_check(input logic [11:0] addr, input logic [7:0] exp);
    logic [7:0] d;
    i_wdog_cpu_model.bus_read(addr, d);
    check(d, exp);
  endtask

  task automatic pulse(ref logic s);
    @(posedge mclk);
    #1;
    s = 1'b1;
    @(posedge mclk);
    #1;
    s = 1'b0;
  endtask

  task automatic pulse_cause(input logic [4:0] c);
    @(posedge mclk);
    #1;
    cause = wdog_pkg::reset_cause_t'(c);
    @(posedge mclk);
    #1;
    cause = '0;
  endtask

  task automatic ticks(input int n);
    @(posedge mclk);
    #1;
    rc_tick = 1'b1;
    repeat (n) @(posedge mclk);
    #1;
    rc_tick = 1'b0;
  endtask

  // Tick every cycle until the selected time-out output shows
  task automatic wait_out(input int which);
    logic found;
    logic sel;
    found   = 1'b0;
    rc_tick = 1'b1;
    for (int i = 0; i < 64 && !found; i++)
    begin
      @(posedge mclk);
      #1;
      sel   = (which == 0) ? trst : (which == 1) ? irq : srec;
      found = (sel === 1'b1);
    end
    if (found)
    begin
      @(posedge mclk);
      #1;
    end
    rc_tick = 1'b0;
    check({7'h0, found}, 8'h01);
    if (!found)
      end_of_test();
  endtask

  // Two-cycle reset, reload of 10h, start
  task automatic restart;
    rst_b = 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    rst_b = 1'b1;
    i_wdog_cpu_model.set_reload(24'h000010);
    pulse(enable);
    rd_check(wdog_pkg::watchdog_control_status_addr, 8'h80);
  endtask

  initial
  begin
    n_errors = 0;
    checked  = 0;
    rst_b    = 1'b0;
    cause    = '0;
    rc_tick  = 1'b0;
    refresh  = 1'b0;
    enable   = 1'b0;
    stop_mode = 1'b0;
    tro      = 1'b0;
    restart();
    rd_check(wdog_pkg::watchdog_control_status_addr, 8'h00);
    for (int i = 0; i < 5; i++)
    begin
      pulse_cause(row_cause[i]);
      rd_check(12'hff0, row_stat[i]);
    end
    // ****************************************
    // Reload, count and lock
    // ****************************************
    rd_check(wdog_pkg::watchdog_reload_high_byte_addr, 8'h00);
    rd_check(wdog_pkg::watchdog_reload_low_byte_addr, 8'h10);
    ticks(5);
    rd_check(wdog_pkg::watchdog_reload_low_byte_addr, 8'h0b);
    i_wdog_cpu_model.bus_write(wdog_pkg::watchdog_reload_low_byte_addr, 8'h33);
    pulse(refresh);
    rd_check(wdog_pkg::watchdog_reload_low_byte_addr, 8'h10);
    i_wdog_cpu_model.unlock();
    i_wdog_cpu_model.bus_write(wdog_pkg::watchdog_reload_high_byte_addr, 8'h44);
    i_wdog_cpu_model.bus_write(wdog_pkg::watchdog_reload_low_byte_addr, 8'h55);
    pulse(refresh);
    rd_check(wdog_pkg::watchdog_reload_high_byte_addr, 8'h00);
    rd_check(wdog_pkg::watchdog_reload_low_byte_addr, 8'h10);
    ticks(14);
    pulse(refresh);
    rd_check(wdog_pkg::watchdog_reload_low_byte_addr, 8'h02);
    // ****************************************
    // Time-outs
    // ****************************************
    wait_out(1);
    ticks(1);
    rd_check(wdog_pkg::watchdog_reload_upper_byte_addr, 8'hff);
    rd_check(wdog_pkg::watchdog_control_status_addr, 8'h20);
    restart();
    stop_mode = 1'b1;
    wait_out(2);
    check({7'h0, run}, 8'h01);
    stop_mode = 1'b0;
    rd_check(wdog_pkg::watchdog_control_status_addr, 8'h60);
    restart();
    tro = 1'b1;
    pulse_cause(5'h01);
    wait_out(0);
    rd_check(wdog_pkg::watchdog_control_status_addr, 8'h20);
    // ****************************************
    // Stop-mode shutoff bit
    // ****************************************
    i_wdog_cpu_model.unlock();
    i_wdog_cpu_model.bus_write(12'hff0, wdog_pkg::shutoff_set_value);
    rd_check(wdog_pkg::watchdog_control_status_addr, 8'h01);
    stop_mode = 1'b1;
    @(posedge mclk);
    #1;
    check({7'h0, run}, 8'h00);
    i_wdog_cpu_model.unlock();
    i_wdog_cpu_model.bus_write(12'hff0, wdog_pkg::shutoff_clear_value);
    rd_check(wdog_pkg::watchdog_control_status_addr, 8'h00);
    check({7'h0, run}, 8'h01);
    end_of_test();
  end
endmodule
